// file: rtl/gpl_top.sv
// pin and led configuration block with apb slave and pin event interrupt
// assumes pins and debug sources synchronous to pclk; one wait state per access
//
// The APB register port was left to the implementer.
`default_nettype none

module gpl_top (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // shared led and general-purpose pins
    input wire logic [2:0] led_src,
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    // serial memory controller
    input wire logic mem_data_out,
    input wire logic mem_data_oe,
    input wire logic mem_clk,
    output logic mem_data_in,
    // debug sources
    input wire logic tx_en,
    input wire logic rx_dv,
    input wire logic tx_clk,
    input wire logic rx_clk,
    // serial memory pins
    input wire logic serial_memory_data_pin_in,
    output logic serial_memory_data_pin_out,
    output logic serial_memory_data_pin_oe,
    output logic serial_memory_clock_pin_out,
    output logic serial_memory_clock_pin_oe
);

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    function automatic logic addr_is(input logic [gpl_pkg::ADDR_W-1:0] a,
                                     input logic [gpl_pkg::ADDR_W-1:0] b);
        addr_is = (a == b);
    endfunction : addr_is

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;
    logic [2:0] sts_r;
    logic [2:0] sts_nxt;
    logic [2:0] en_r;
    logic [2:0] en_nxt;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    logic [31:0] prdata_r;
    gpl_pkg::gpl_cfg_t cfg;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire access = psel & penable;
    wire first = access & ~pready_r;
    wire done = access & pready_r;
    wire hit_cfg = addr_is(paddr, gpl_pkg::CFG_ADDR);
    wire hit_sts = addr_is(paddr, gpl_pkg::STS_ADDR);
    wire hit_en = addr_is(paddr, gpl_pkg::EN_ADDR);
    wire mapped = hit_cfg | hit_sts | hit_en;
    wire wr_done = done & pwrite & mapped;
    wire [31:0] be = strb_mask(pstrb);
    // reserved bits never reach the register
    wire [31:0] cfg_be = be & gpl_pkg::CFG_WMASK;
    wire [2:0] sts_w1c = (wr_done & hit_sts) ? (pwdata[2:0] & be[2:0]) : 3'h0;

    assign cfg = gpl_pkg::gpl_cfg_t'(cfg_r);

    // ----------------------------------------------------------------
    // pins and events
    // ----------------------------------------------------------------
    // active level per pin follows the polarity setting
    wire [2:0] pin_act = ~(pin_in ^ cfg.pin_event_polarity);
    wire [2:0] pin_evt;

    genvar gi;
    generate
        for (gi = 0; gi < gpl_pkg::NPIN; gi++) begin : g_pin
            gpl_pin_cell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .led_sel(cfg.led_function_select[gi]),
                .push_pull(cfg.pin_driver_type[gi]),
                .drive_out(cfg.pin_direction[gi]),
                .data_val(cfg.pin_value[gi]),
                .led_src(led_src[gi]),
                .level_act(pin_act[gi]),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi]),
                .pin_evt(pin_evt[gi])
            );
        end
    endgenerate

    // software must keep the select stable during memory cycles and avoid
    // the reserved codes; the router only releases the pins for those
    gpl_sm_route u_route (
        .pclk(pclk),
        .presetn(presetn),
        .route(cfg.serial_memory_pin_select),
        .output_only_pin_3(cfg.output_only_value[0]),
        .output_only_pin_4(cfg.output_only_value[1]),
        .mem_data_out(mem_data_out),
        .mem_data_oe(mem_data_oe),
        .mem_clk(mem_clk),
        .mem_data_in(mem_data_in),
        .tx_en(tx_en),
        .rx_dv(rx_dv),
        .tx_clk(tx_clk),
        .rx_clk(rx_clk),
        .data_pin_in(serial_memory_data_pin_in),
        .data_pin_out(serial_memory_data_pin_out),
        .data_pin_oe(serial_memory_data_pin_oe),
        .clk_pin_out(serial_memory_clock_pin_out),
        .clk_pin_oe(serial_memory_clock_pin_oe)
    );

    // ----------------------------------------------------------------
    // register next values
    // ----------------------------------------------------------------
    // byte-enabled writes; the status clear loses to a new event
    assign cfg_nxt = (wr_done & hit_cfg) ? ((cfg_r & ~cfg_be) | (pwdata & cfg_be)) : cfg_r;
    assign en_nxt = (wr_done & hit_en) ? ((en_r & ~be[2:0]) | (pwdata[2:0] & be[2:0])) : en_r;
    assign sts_nxt = (sts_r & ~sts_w1c) | pin_evt;

    // read mux; pin value bits show the live pin level, not the stored value
    wire [31:0] rd_cfg = {cfg_r[31:3] & gpl_pkg::CFG_WMASK[31:3], pin_in};
    wire [31:0] rd_mux = hit_cfg ? rd_cfg :
                         hit_sts ? {29'h0, sts_r} :
                         hit_en ? {29'h0, en_r} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // one wait state keeps every bus output on a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= first;
            pslverr_r <= first & ~mapped;
            prdata_r <= (first & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // configuration, status and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= gpl_pkg::CFG_RST;
            sts_r <= gpl_pkg::EVT_RST;
            en_r <= gpl_pkg::EVT_RST;
            irq_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            sts_r <= sts_nxt;
            en_r <= en_nxt;
            irq_r <= |(sts_r & en_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_led_drive: assert property (
        (cfg.led_function_select == 3'h7) |=> (pin_oe == 3'h7) && (pin_out == $past(led_src))
    ) else $error("led pins not driven from led source");

    chk_event_polarity: assert property (
        $rose(sts_r[0]) |-> $past(pin_in[0]) == $past(cfg.pin_event_polarity[0])
    ) else $error("pin event set at the wrong level");

    chk_irq_gate: assert property (
        ((sts_r & en_r) == 3'h0) |=> !irq
    ) else $error("interrupt raised without an enabled event");

    chk_irq_raise: assert property (
        ((sts_r & en_r) != 3'h0) |=> irq
    ) else $error("enabled event did not raise the interrupt");

    chk_filter_width: assert property (
        $rose(sts_r[0]) |-> $past(pin_act[0], 1) && $past(pin_act[0], 11)
    ) else $error("pin event accepted from too short a level");

    chk_route_gpo: assert property (
        (cfg.serial_memory_pin_select == gpl_pkg::ROUTE_GPO) |=>
            serial_memory_data_pin_out == $past(cfg.output_only_value[0]) &&
            serial_memory_clock_pin_out == $past(cfg.output_only_value[1])
    ) else $error("output-only values not on the memory pins");

    chk_route_clks: assert property (
        (cfg.serial_memory_pin_select == gpl_pkg::ROUTE_CLKS) |=>
            serial_memory_data_pin_out == $past(tx_clk) &&
            serial_memory_clock_pin_out == $past(rx_clk)
    ) else $error("debug clocks not routed to the memory pins");

    chk_open_drain: assert property (
        (!cfg.led_function_select[1] && cfg.pin_direction[1] && !cfg.pin_driver_type[1])
            |=> !pin_out[1] && (pin_oe[1] == !$past(cfg.pin_value[1]))
    ) else $error("open-drain pin drove high");

    chk_dir_input: assert property (
        (!cfg.led_function_select[0] && !cfg.pin_direction[0]) |=> !pin_oe[0]
    ) else $error("input pin is driven");

    chk_pin_readback: assert property (
        (pready && !pwrite && hit_cfg) |-> prdata[2:0] == $past(pin_in)
    ) else $error("pin value read not the live level");

    chk_reserved_zero: assert property (
        (pready && !pwrite) |-> (prdata[31:3] & ~gpl_pkg::CFG_WMASK[31:3]) == 29'h0
    ) else $error("reserved bits read non-zero");

    chk_bus_answer: assert property (
        (psel && penable && !pready) |=> pready
    ) else $error("access phase not answered in one wait state");

    cov_event_irq: cover property ($rose(irq));
    cov_cfg_write: cover property (pready && pwrite && hit_cfg);
    cov_w1c_clear: cover property (sts_r[0] ##1 !sts_r[0]);
    cov_led_mode: cover property (cfg.led_function_select != 3'h0);

endmodule : gpl_top

`default_nettype wire

// file: rtl/gpl_pkg.sv
// package of constants and types for the pin and led configuration block
// assumes a single 250 MHz clock and an apb register bus with 32-bit data
//
// Overview of operation
// - a one in a led select bit turns that shared pin into a led output
// - polarity bit one: high level flags the pin event; zero: low level flags it
// - a pin event raises the interrupt only when its enable bit is set
// - a pin level counts as an event only after more than 40 ns active
// - three-bit select routes the serial memory data and clock pins per code
// - driver type bit one gives push-pull output, zero gives open-drain
// - direction bit one makes the pin an output, zero an input
// - bits 4 and 3 drive output-only pins 4 and 3 when selected
// - pin value bits drive outputs; reading them returns the live pin levels
`default_nettype none

package gpl_pkg;

    // ----------------------------------------------------------------
    // bus and register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CFG_ADDR = 12'h088;
    localparam logic [ADDR_W-1:0] STS_ADDR = 12'h0c0;
    localparam logic [ADDR_W-1:0] EN_ADDR = 12'h0c4;
    localparam logic [31:0] CFG_WMASK = 32'h7777_071f;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [2:0] EVT_RST = 3'h0;
    localparam int NPIN = 3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 4;
    localparam int FILT_NS = 40;
    // least time, rounded up to whole cycles
    localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILT_W = $clog2(FILT_CYC + 1);
    localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(FILT_CYC);

    // ----------------------------------------------------------------
    // serial memory pin routing codes
    // ----------------------------------------------------------------
    localparam logic [2:0] ROUTE_MEM = 3'h0;
    localparam logic [2:0] ROUTE_GPO = 3'h1;
    localparam logic [2:0] ROUTE_OUTPUT_ONLY_PIN_3_RXDV = 3'h3;
    localparam logic [2:0] ROUTE_TXEN_OUTPUT_ONLY_PIN_4 = 3'h5;
    localparam logic [2:0] ROUTE_TXEN_RXDV = 3'h6;
    localparam logic [2:0] ROUTE_CLKS = 3'h7;

    // ----------------------------------------------------------------
    // configuration word, msb first
    // ----------------------------------------------------------------
    typedef struct packed {
        logic rsv31;
        logic [2:0] led_function_select;
        logic rsv27;
        logic [2:0] pin_event_polarity;
        logic rsv23;
        logic [2:0] serial_memory_pin_select;
        logic rsv19;
        logic [2:0] pin_driver_type;
        logic [4:0] rsv15_11;
        logic [2:0] pin_direction;
        logic [2:0] rsv7_5;
        logic [1:0] output_only_value;
        logic [2:0] pin_value;
    } gpl_cfg_t;

endpackage : gpl_pkg

`default_nettype wire

// file: rtl/gpl_pin_cell.sv
// one shared pin: led or general-purpose output driver plus level filter
// assumes pin levels are already synchronous to pclk
`default_nettype none

module gpl_pin_cell (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    input wire logic led_sel,
    input wire logic push_pull,
    input wire logic drive_out,
    input wire logic data_val,
    // led source and active level of the pin
    input wire logic led_src,
    input wire logic level_act,
    // pin drive and qualified event
    output logic pin_out,
    output logic pin_oe,
    output logic pin_evt
);

    logic [gpl_pkg::FILT_W-1:0] cnt_r;
    logic out_nxt;
    logic oe_nxt;
    logic qual;

    // led wins over pin control; open-drain only ever pulls low
    assign out_nxt = led_sel ? led_src : (push_pull & data_val);
    assign oe_nxt = led_sel | (drive_out & (push_pull | ~data_val));
    // the level must persist beyond the filter window before it counts
    assign qual = level_act & (cnt_r == gpl_pkg::FILT_MAX);
    assign pin_evt = qual & ~led_sel;

    // output flops and saturating run-length counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            cnt_r <= '0;
        end else begin
            pin_out <= out_nxt;
            pin_oe <= oe_nxt;
            if (!level_act) begin
                cnt_r <= '0;
            end else if (cnt_r != gpl_pkg::FILT_MAX) begin
                cnt_r <= cnt_r + {{(gpl_pkg::FILT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule : gpl_pin_cell

`default_nettype wire

// file: rtl/gpl_sm_route.sv
// routes the serial memory data and clock pins to memory, output-only or debug
// assumes all sources are synchronous to pclk; pins are registered once
`default_nettype none

module gpl_sm_route (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // selection and output-only values
    input wire logic [2:0] route,
    input wire logic output_only_pin_3,
    input wire logic output_only_pin_4,
    // serial memory controller side
    input wire logic mem_data_out,
    input wire logic mem_data_oe,
    input wire logic mem_clk,
    output logic mem_data_in,
    // debug sources
    input wire logic tx_en,
    input wire logic rx_dv,
    input wire logic tx_clk,
    input wire logic rx_clk,
    // pins
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe,
    output logic clk_pin_out,
    output logic clk_pin_oe
);

    logic d_nxt;
    logic doe_nxt;
    logic c_nxt;
    logic coe_nxt;

    // route table; reserved codes release both pins as the safe choice
    always_comb begin
        d_nxt = 1'b0;
        doe_nxt = 1'b1;
        c_nxt = 1'b0;
        coe_nxt = 1'b1;
        case (route)
            gpl_pkg::ROUTE_MEM: begin
                d_nxt = mem_data_out;
                doe_nxt = mem_data_oe;
                c_nxt = mem_clk;
            end
            gpl_pkg::ROUTE_GPO: begin
                d_nxt = output_only_pin_3;
                c_nxt = output_only_pin_4;
            end
            gpl_pkg::ROUTE_OUTPUT_ONLY_PIN_3_RXDV: begin
                d_nxt = output_only_pin_3;
                c_nxt = rx_dv;
            end
            gpl_pkg::ROUTE_TXEN_OUTPUT_ONLY_PIN_4: begin
                d_nxt = tx_en;
                c_nxt = output_only_pin_4;
            end
            gpl_pkg::ROUTE_TXEN_RXDV: begin
                d_nxt = tx_en;
                c_nxt = rx_dv;
            end
            gpl_pkg::ROUTE_CLKS: begin
                d_nxt = tx_clk;
                c_nxt = rx_clk;
            end
            default: begin
                doe_nxt = 1'b0;
                coe_nxt = 1'b0;
            end
        endcase
    end

    // pin flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_pin_out <= 1'b0;
            data_pin_oe <= 1'b0;
            clk_pin_out <= 1'b0;
            clk_pin_oe <= 1'b0;
            mem_data_in <= 1'b0;
        end else begin
            data_pin_out <= d_nxt;
            data_pin_oe <= doe_nxt;
            clk_pin_out <= c_nxt;
            clk_pin_oe <= coe_nxt;
            mem_data_in <= data_pin_in;
        end
    end

endmodule : gpl_sm_route

`default_nettype wire

// file: tb/gpl_board.sv
// board model: pull-ups on the shared pins and the serial memory data pin
// assumes the bench commands the external drivers ext_oe and ext_val
`default_nettype none

module gpl_board (
    // block pin drive
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic sd_out,
    input wire logic sd_oe,
    // external drivers
    input wire logic [2:0] ext_oe,
    input wire logic [2:0] ext_val,
    // resolved levels
    output logic [2:0] pin_lvl,
    output logic sd_lvl
);
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------
    // wire resolution
    // --------------------
    // two drivers at once is a short, shown as unknown, not silently resolved
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (pin_oe[i] && ext_oe[i]) begin
                pin_lvl[i] = 1'bx;
            end else if (pin_oe[i]) begin
                pin_lvl[i] = pin_out[i];
            end else begin
                pin_lvl[i] = ext_oe[i] ? ext_val[i] : 1'b1;
            end
        end
    end
    // released data pin floats up through its pull-up
    assign sd_lvl = sd_oe ? sd_out : 1'b1;
endmodule : gpl_board

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the pin and led configuration block
// assumes the board model pulls released pins high; apb master lives here
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------
    // signals
    // --------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [gpl_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [2:0] led_src, pin_in, pin_out, pin_oe, ext_oe, ext_val;
    logic mem_data_out, mem_data_oe, mem_clk, mem_data_in;
    logic tx_en, rx_dv, tx_clk, rx_clk, sd_in, sd_out, sd_oe, sc_out, sc_oe;
    int n_mismatch, n_tests;

    gpl_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .led_src(led_src), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_clk(mem_clk),
        .mem_data_in(mem_data_in), .tx_en(tx_en), .rx_dv(rx_dv), .tx_clk(tx_clk),
        .rx_clk(rx_clk), .serial_memory_data_pin_in(sd_in),
        .serial_memory_data_pin_out(sd_out), .serial_memory_data_pin_oe(sd_oe),
        .serial_memory_clock_pin_out(sc_out), .serial_memory_clock_pin_oe(sc_oe));

    gpl_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .sd_out(sd_out),
        .sd_oe(sd_oe), .ext_oe(ext_oe), .ext_val(ext_val), .pin_lvl(pin_in),
        .sd_lvl(sd_in));

    // 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // --------------------
    // shared tasks
    // --------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) chk("pready", 32'h0000_0001, 32'h0000_0000);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rdchk

    // lets pins settle past the registered latency, sampled off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle

    // --------------------
    // scenarios
    // --------------------
    task automatic t_reset();
        chk("oe_rst", 32'h0000_0000, {29'h0, pin_oe});
        rdchk("cfg_rst", gpl_pkg::CFG_ADDR, 32'h0000_0007);
        rdchk("sts_rst", gpl_pkg::STS_ADDR, 32'h0000_0000);
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk("bad_err", 32'h0000_0001, {31'h0, er});
        chk("bad_rd", 32'h0000_0000, rd);
        wr(gpl_pkg::CFG_ADDR, 32'hffff_ffff);
        settle(2);
        rdchk("cfg_rsv", gpl_pkg::CFG_ADDR, 32'h7777_071d);
        $display("test reset done");
    endtask : t_reset

    task automatic t_led();
        chk("led_oe", 32'h0000_0007, {29'h0, pin_oe});
        chk("led_out", 32'h0000_0005, {29'h0, pin_out});
        @(posedge pclk);
        led_src <= 3'h2;
        settle(3);
        chk("led_flw", 32'h0000_0002, {29'h0, pin_out});
        wr(gpl_pkg::CFG_ADDR, 32'h0000_0000);
        settle(3);
        chk("in_oe", 32'h0000_0000, {29'h0, pin_oe});
        $display("test led done");
    endtask : t_led

    // pin0 input, pin1 open-drain, pin2 push-pull
    task automatic drv(input logic [31:0] w, input logic [2:0] eoe, input logic [2:0] eo);
        wr(gpl_pkg::CFG_ADDR, w);
        settle(3);
        chk("drv_oe", {29'h0, eoe}, {29'h0, pin_oe});
        chk("drv_out", {29'h0, eo}, {29'h0, pin_out & pin_oe});
        rdchk("live", gpl_pkg::CFG_ADDR, w | 32'h0000_0001);
    endtask : drv

    task automatic t_drive();
        drv(32'h0004_0600, 3'h6, 3'h0);
        drv(32'h0004_0606, 3'h4, 3'h4);
        $display("test drive done");
    endtask : t_drive

    task automatic t_route();
        logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
        logic [1:0] g;
        logic ed, ec;
        for (int p = 0; p < 2; p++) begin
            @(posedge pclk);
            {mem_data_out, mem_clk, tx_en, rx_dv, tx_clk, rx_clk} <= p ? 6'h15 : 6'h2a;
            mem_data_oe <= (p == 1);
            g = p ? 2'h1 : 2'h2;
            foreach (codes[k]) begin
                wr(gpl_pkg::CFG_ADDR, (32'(codes[k]) << 20) | (32'(g) << 3));
                settle(3);
                case (codes[k])
                    3'h0: {ed, ec} = {mem_data_out, mem_clk};
                    3'h1: {ed, ec} = {g[0], g[1]};
                    3'h3: {ed, ec} = {g[0], rx_dv};
                    3'h5: {ed, ec} = {tx_en, g[1]};
                    3'h6: {ed, ec} = {tx_en, rx_dv};
                    default: {ed, ec} = {tx_clk, rx_clk};
                endcase
                chk("clk_pin", {30'h0, 1'b1, ec}, {30'h0, sc_oe, sc_out});
                if (codes[k] == 3'h0 && !mem_data_oe) begin
                    chk("mem_in", 32'h0000_0001, {31'h0, mem_data_in});
                    chk("dat_oe", 32'h0000_0000, {31'h0, sd_oe});
                end else begin
                    chk("dat_pin", {30'h0, 1'b1, ed}, {30'h0, sd_oe, sd_out});
                end
            end
        end
        $display("test route done");
    endtask : t_route

    // external low on pin0 held for n cycles, then released
    task automatic pulse(input int n);
        @(posedge pclk);
        ext_oe[0] <= 1'b1;
        repeat (n) @(posedge pclk);
        ext_oe[0] <= 1'b0;
        settle(4);
    endtask : pulse

    task automatic t_irq();
        wr(gpl_pkg::CFG_ADDR, 32'h0000_0000);
        settle(2);
        wr(gpl_pkg::STS_ADDR, 32'h0000_0007);
        rdchk("sts_clr", gpl_pkg::STS_ADDR, 32'h0000_0000);
        pulse(10);
        rdchk("sts_shrt", gpl_pkg::STS_ADDR, 32'h0000_0000);
        pulse(20);
        rdchk("sts_low", gpl_pkg::STS_ADDR, 32'h0000_0001);
        chk("irq_msk", 32'h0000_0000, {31'h0, irq});
        wr(gpl_pkg::EN_ADDR, 32'h0000_0001);
        settle(2);
        chk("irq_on", 32'h0000_0001, {31'h0, irq});
        wr(gpl_pkg::STS_ADDR, 32'h0000_0001);
        settle(2);
        chk("irq_clr", 32'h0000_0000, {31'h0, irq});
        wr(gpl_pkg::CFG_ADDR, 32'h0200_0000);
        settle(20);
        rdchk("sts_high", gpl_pkg::STS_ADDR, 32'h0000_0002);
        chk("irq_pin1", 32'h0000_0000, {31'h0, irq});
        $display("test irq done");
    endtask : t_irq

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        led_src = 3'h5;
        {ext_oe, ext_val} = 6'h00;
        {mem_data_out, mem_data_oe, mem_clk} = 3'h0;
        {tx_en, rx_dv, tx_clk, rx_clk} = 4'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        t_reset();
        t_led();
        t_drive();
        t_route();
        t_irq();
        conclude();
    end

    // watchdog: the tests need about three hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        conclude();
    end
endmodule : tb

`default_nettype wire
